//--- rtl/rsp_pkg.sv
// Purpose: constants and types of the radio/converter serial command port
// Assumes: byte opcodes, mode 0 serial framing, bytes sent msb first
// Notes:   status bit layout and radio byte layout are local choices
package rsp_pkg;
    // opcodes, whole bytes or upper bits as noted
    localparam logic [3:0] OP_WRITE_RADIO_SETUP = 4'h0;
    localparam logic [3:0] OP_READ_RADIO_SETUP  = 4'h1;
    localparam logic [7:0] OP_WTP    = 8'h20;
    localparam logic [7:0] OP_RTP    = 8'h21;
    localparam logic [7:0] OP_WTA    = 8'h22;
    localparam logic [7:0] OP_RTA    = 8'h23;
    localparam logic [7:0] OP_RRP    = 8'h24;
    localparam logic [6:0] OP_RAD_HI = 7'h20;
    localparam logic [7:0] OP_WAC    = 8'h44;
    localparam logic [7:0] OP_RAC    = 8'h46;
    localparam logic [3:0] OP_CC_HI  = 4'h8;
    localparam logic [3:0] OP_SAC_HI = 4'hc;
    // register sizes in bytes, and the largest byte index
    localparam int         RF_NBYTES = 10;
    localparam logic [5:0] TXA_LEN   = 6'h04;
    localparam logic [5:0] PAY_LEN   = 6'h20;
    localparam logic [5:0] ADCD_LEN  = 6'h02;
    localparam logic [5:0] ADCC_LEN  = 6'h03;
    localparam logic [5:0] IDX_MAX   = 6'h3f;
    // status bit positions
    localparam int ST_RDY   = 0;
    localparam int ST_MATCH = 1;
    localparam int ST_EOC = 2;
    localparam int ST_RNG = 3;
    // radio byte 0 = channel[7:0]; byte 1[3:0] = {power, band, channel[8]}
    localparam int CH_LO_BYTE = 0;
    localparam int CH_HI_BYTE = 1;
    // reset values
    localparam logic [7:0] RF_B0_RST = 8'h6c;
    localparam logic [7:0] BYTE_RST  = 8'h00;
    typedef enum {S_IDLE, S_OPC, S_DATA, S_IGN} rsp_state_e;
    typedef enum {T_NONE, T_RF, T_TXP, T_TXA, T_RXP, T_ADCD, T_ADCC,
                  T_CH} rsp_tgt_e;
endpackage

//--- rtl/rsp_sync2.sv
// Purpose: two-stage synchroniser for pin-level inputs
// Assumes: inputs are slow levels relative to mclk
// Notes:   the first stage feeds only the second
`timescale 1ns/1ps
module rsp_sync2 #(
    parameter int W = 1
) (
    // clock and control
    input  wire logic         mclk,
    input  wire logic         srst,
    input  wire logic         ce,
    // levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // both stages reset low; no logic between them
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            meta_reg <= '0;
            q        <= '0;
        end
        else if (ce)
        begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule // rsp_sync2

//--- rtl/rsp_cmd_port.sv
// Purpose: serial command interpreter for radio and converter registers
// Assumes: sck, mosi, select_low come from pins; sck well below mclk/6
// Notes:   rx payload is filled by the packet engine over its own port
`timescale 1ns/1ps
module rsp_cmd_port
    import rsp_pkg::*;
#(
    parameter int RF_BYTES = RF_NBYTES
) (
    // clock and control
    input  wire logic                  mclk,
    input  wire logic                  srst,
    input  wire logic                  ce,
    // serial pins
    input  wire logic                  sck_pin,
    input  wire logic                  mosi_pin,
    input  wire logic                  select_low,
    output logic                       miso,
    output logic                       miso_oe,
    // transceiver state and flags
    input  wire logic                  standby,
    input  wire logic                  data_ready_flag,
    input  wire logic                  address_match_flag,
    input  wire logic                  conversion_done_flag,
    input  wire logic                  adc_range_flag,
    input  wire logic [15:0]           adc_result,
    // packet engine payload ports
    input  wire logic                  rx_wr_en,
    input  wire logic [4:0]            rx_wr_idx,
    input  wire logic [7:0]            rx_wr_data,
    input  wire logic [4:0]            tx_rd_idx,
    output logic      [7:0]            tx_rd_data,
    // configuration outputs
    output logic      [RF_BYTES*8-1:0] rf_setup_reg,
    output logic      [31:0]           tx_address_reg,
    output logic      [15:0]           adc_setup_reg,
    output logic                       conv_start,
    output logic      [3:0]            adc_input_select
);
    logic [2:0]  pin_s;
    logic        sck_s;
    logic        mosi_s;
    logic        selb_s;
    logic        sck_q;
    logic        selb_q;
    logic        sck_rise;
    logic        sck_fall;
    logic        sel_fall;
    rsp_state_e  state_reg;
    logic [2:0]  bit_reg;
    logic [6:0]  sh_in_reg;
    logic [7:0]  sh_out_reg;
    logic [7:0]  byte_in;
    logic        byte_done;
    logic [7:0]  status_byte;
    rsp_tgt_e    tgt_reg;
    logic        wr_reg;
    logic [5:0]  idx_reg;
    logic [3:0]  cc_bits_reg;
    logic        conv_pend_reg;
    logic        wr_fire;
    rsp_tgt_e    dec_tgt;
    logic        dec_ok;
    logic        dec_wr;
    logic        dec_conv;
    logic [5:0]  dec_idx;
    rsp_tgt_e    sel_tgt;
    logic [5:0]  sel_idx;
    logic [7:0]  rd_byte;
    logic [7:0]  txp_mem [32];
    logic [7:0]  rxp_mem [32];

    // all three pins cross into mclk through two flops; select crosses
    // inverted so the synchroniser's low reset level reads as deselected
    // and no false select edge follows reset
    rsp_sync2 #(.W(3)) u_sync (
        .mclk (mclk),
        .srst (srst),
        .ce   (ce),
        .d    ({sck_pin, mosi_pin, ~select_low}),
        .q    (pin_s)
    );
    assign {sck_s, mosi_s} = pin_s[2:1];
    assign selb_s          = ~pin_s[0];

    // edge history on the synchronised copies
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            sck_q  <= 1'b0;
            selb_q <= 1'b1;
        end
        else if (ce)
        begin
            sck_q  <= sck_s;
            selb_q <= selb_s;
        end
    end

    // mode 0: sample on rising sck, shift out on falling
    assign sck_rise = ce & sck_s & ~sck_q;
    assign sck_fall = ce & ~sck_s & sck_q;
    assign sel_fall = ce & selb_q & ~selb_s;
    assign byte_in  = {sh_in_reg, mosi_s};
    assign byte_done = sck_rise & ~selb_s & ~sel_fall & (bit_reg == 3'h7);

    // status byte built from live flags
    always_comb
    begin
        status_byte         = 8'h00;
        status_byte[ST_RDY]   = data_ready_flag;
        status_byte[ST_MATCH] = address_match_flag;
        status_byte[ST_EOC] = conversion_done_flag;
        status_byte[ST_RNG] = adc_range_flag;
    end

    function automatic logic [5:0] tgt_len(rsp_tgt_e t);
        case (t)
            T_RF:    tgt_len = 6'(RF_BYTES);
            T_TXP:   tgt_len = PAY_LEN;
            T_RXP:   tgt_len = PAY_LEN;
            T_TXA:   tgt_len = TXA_LEN;
            T_ADCD:  tgt_len = ADCD_LEN;
            T_ADCC:  tgt_len = ADCC_LEN;
            T_CH:    tgt_len = 6'h01;
            default: tgt_len = 6'h00;
        endcase
    endfunction

    // opcode decode of the byte just completed
    always_comb
    begin
        dec_ok   = 1'b1;
        dec_wr   = 1'b0;
        dec_conv = 1'b0;
        dec_tgt  = T_NONE;
        dec_idx  = 6'h00;
        if (byte_in[7:4] == OP_WRITE_RADIO_SETUP
            || byte_in[7:4] == OP_READ_RADIO_SETUP)
        begin
            dec_tgt = T_RF;
            dec_wr  = (byte_in[7:4] == OP_WRITE_RADIO_SETUP);
            dec_idx = {2'h0, byte_in[3:0]};
        end
        else if (byte_in[7:1] == OP_RAD_HI)
        begin
            dec_tgt = T_ADCD;
            dec_idx = {5'h00, byte_in[0]};
        end
        else if (byte_in[7:4] == OP_CC_HI)
        begin
            dec_tgt = T_CH;
            dec_wr  = 1'b1;
        end
        else if (byte_in[7:4] == OP_SAC_HI)
            dec_conv = 1'b1;
        else
        begin
            case (byte_in)
                OP_WTP:  dec_tgt = T_TXP;
                OP_RTP:  dec_tgt = T_TXP;
                OP_WTA:  dec_tgt = T_TXA;
                OP_RTA:  dec_tgt = T_TXA;
                OP_RRP:  dec_tgt = T_RXP;
                OP_WAC:  dec_tgt = T_ADCC;
                OP_RAC:  dec_tgt = T_ADCC;
                default: dec_ok  = 1'b0;
            endcase
            dec_wr = (byte_in == OP_WTP) | (byte_in == OP_WTA)
                   | (byte_in == OP_WAC);
        end
    end

    // next byte to shift out: first of a read, or the following one
    always_comb
    begin
        sel_tgt = tgt_reg;
        sel_idx = idx_reg + 6'h01;
        if (state_reg == S_OPC)
        begin
            sel_tgt = (dec_ok && !dec_wr) ? dec_tgt : T_NONE;
            sel_idx = dec_idx;
        end
        // ignored frames and writes shift zeros, never stale read context
        if ((state_reg == S_DATA && wr_reg) || state_reg == S_IGN)
            sel_tgt = T_NONE;
        rd_byte = 8'h00;
        if (sel_idx < tgt_len(sel_tgt))
        begin
            // every written register has a read path here
            case (sel_tgt)
                T_RF:    rd_byte = rf_setup_reg[8*sel_idx +: 8];
                T_TXP:   rd_byte = txp_mem[sel_idx[4:0]];
                T_RXP:   rd_byte = rxp_mem[sel_idx[4:0]];
                T_TXA:   rd_byte = tx_address_reg[8*sel_idx[1:0] +: 8];
                T_ADCD:  rd_byte = adc_result[8*sel_idx[0] +: 8];
                T_ADCC:  rd_byte = sel_idx[1] ? 8'h00
                                 : adc_setup_reg[8*sel_idx[0] +: 8];
                default: rd_byte = 8'h00;
            endcase
        end
    end

    // framing, bit counter and shift registers
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            state_reg  <= S_IDLE;
            bit_reg    <= 3'h0;
            sh_in_reg  <= 7'h00;
            sh_out_reg <= 8'h00;
            miso       <= 1'b0;
            miso_oe    <= 1'b0;
        end
        else if (ce)
        begin
            if (selb_s)
            begin
                state_reg <= S_IDLE;
                miso      <= 1'b0;
                miso_oe   <= 1'b0;
            end
            else if (sel_fall)
            begin
                // outside standby the whole frame is ignored
                state_reg  <= standby ? S_OPC : S_IGN;
                bit_reg    <= 3'h0;
                miso       <= status_byte[7];
                sh_out_reg <= {status_byte[6:0], 1'b0};
                miso_oe    <= 1'b1;
            end
            else
            begin
                if (sck_fall)
                begin
                    miso       <= sh_out_reg[7];
                    sh_out_reg <= {sh_out_reg[6:0], 1'b0};
                end
                if (sck_rise)
                begin
                    sh_in_reg <= byte_in[6:0];
                    bit_reg   <= bit_reg + 3'h1;
                end
                if (byte_done)
                begin
                    sh_out_reg <= rd_byte;
                    case (state_reg)
                        S_OPC:
                            state_reg <= (dec_ok && !dec_conv) ? S_DATA
                                                                 : S_IGN;
                        S_DATA:  state_reg <= S_DATA;
                        S_IGN:   state_reg <= S_IGN;
                        default: state_reg <= S_IDLE;
                    endcase
                end
            end
        end
    end

    // command context captured from the opcode
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            tgt_reg     <= T_NONE;
            wr_reg      <= 1'b0;
            idx_reg     <= 6'h00;
            cc_bits_reg <= 4'h0;
        end
        else if (byte_done && state_reg == S_OPC)
        begin
            tgt_reg     <= dec_tgt;
            wr_reg      <= dec_wr;
            idx_reg     <= dec_idx;
            cc_bits_reg <= byte_in[3:0];
        end
        else if (byte_done && state_reg == S_DATA && idx_reg != IDX_MAX)
            idx_reg <= idx_reg + 6'h01;
    end

    // bytes past the end of the register fall on the floor
    assign wr_fire = byte_done & (state_reg == S_DATA) & wr_reg
                   & (idx_reg < tgt_len(tgt_reg));

    // radio setup: plain writes and the channel shortcut
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            rf_setup_reg <= '0;
            rf_setup_reg[8*CH_LO_BYTE +: 8] <= RF_B0_RST;
        end
        else if (wr_fire && tgt_reg == T_RF)
            rf_setup_reg[8*idx_reg +: 8] <= byte_in;
        else if (wr_fire && tgt_reg == T_CH)
        begin
            rf_setup_reg[8*CH_LO_BYTE +: 8] <= byte_in;
            rf_setup_reg[8*CH_HI_BYTE +: 4] <= cc_bits_reg;
        end
    end

    // target address and adc setup; byte two of adc setup is dropped
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            tx_address_reg <= {4{BYTE_RST}};
            adc_setup_reg  <= {2{BYTE_RST}};
        end
        else if (wr_fire && tgt_reg == T_TXA)
            tx_address_reg[8*idx_reg[1:0] +: 8] <= byte_in;
        else if (wr_fire && tgt_reg == T_ADCC && !idx_reg[1])
            adc_setup_reg[8*idx_reg[0] +: 8] <= byte_in;
    end

    // payload memories; not reset, content is valid only after a write
    always_ff @(posedge mclk)
    begin
        if (wr_fire && tgt_reg == T_TXP)
            txp_mem[idx_reg[4:0]] <= byte_in;
        if (ce && rx_wr_en)
            rxp_mem[rx_wr_idx] <= rx_wr_data;
    end

    // packet engine read port, one cycle latency
    always_ff @(posedge mclk)
    begin
        if (srst)
            tx_rd_data <= 8'h00;
        else if (ce)
            tx_rd_data <= txp_mem[tx_rd_idx];
    end

    // conversion launches only once select is raised again
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            conv_pend_reg    <= 1'b0;
            conv_start       <= 1'b0;
            adc_input_select <= 4'h0;
        end
        else if (ce)
        begin
            conv_start <= 1'b0;
            if (selb_s && conv_pend_reg)
            begin
                conv_start    <= 1'b1;
                conv_pend_reg <= 1'b0;
            end
            else if (byte_done && state_reg == S_OPC && dec_conv)
            begin
                conv_pend_reg    <= 1'b1;
                adc_input_select <= byte_in[3:0];
            end
        end
    end

    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    property p_status_first;
        sel_fall |=> miso == $past(status_byte[7]);
    endproperty
    a_status_first: assert property (p_status_first)
        else $error("status msb not on miso after select fell");

    property p_standby;
        sel_fall && !standby |=> state_reg == S_IGN;
    endproperty
    a_standby: assert property (p_standby)
        else $error("frame served outside standby");

    property p_opcode;
        sel_fall && standby |=> state_reg == S_OPC && bit_reg == 3'h0;
    endproperty
    a_opcode: assert property (p_opcode)
        else $error("opcode phase not entered");

    property p_ignore;
        state_reg == S_IGN
        |=> $stable(rf_setup_reg) && $stable(tx_address_reg)
            && $stable(adc_setup_reg);
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("write while ignoring");

    property p_deselect;
        ce && selb_s |=> state_reg == S_IDLE && !miso_oe;
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("transfer kept after select rose");

    property p_txp_start;
        byte_done && state_reg == S_OPC && byte_in == OP_WTP
        |=> idx_reg == 6'h00 && tgt_reg == T_TXP && wr_reg;
    endproperty
    a_txp_start: assert property (p_txp_start)
        else $error("tx payload write not from byte zero");

    property p_adc_start;
        byte_done && state_reg == S_OPC && byte_in[7:1] == OP_RAD_HI
        |=> tgt_reg == T_ADCD && idx_reg[0] == $past(byte_in[0]);
    endproperty
    a_adc_start: assert property (p_adc_start)
        else $error("adc result start byte wrong");

    property p_conv;
        byte_done && state_reg == S_OPC && byte_in[7:4] == OP_SAC_HI
        |=> adc_input_select == $past(byte_in[3:0]) && !conv_start;
    endproperty
    a_conv: assert property (p_conv)
        else $error("conversion input not captured");

    property p_channel;
        wr_fire && tgt_reg == T_CH
        |=> rf_setup_reg[11:0] == {$past(cc_bits_reg), $past(byte_in)};
    endproperty
    a_channel: assert property (p_channel)
        else $error("channel shortcut wrote wrong bits");

    property p_incr;
        byte_done && state_reg == S_DATA && idx_reg != IDX_MAX
        |=> idx_reg == $past(idx_reg) + 6'h01;
    endproperty
    a_incr: assert property (p_incr)
        else $error("byte index did not advance");

    c_rf_write: cover property (wr_fire && tgt_reg == T_RF);
    c_rxp_read: cover property (byte_done && tgt_reg == T_RXP);
    c_conv:     cover property (conv_start);
endmodule // rsp_cmd_port

//--- tb/rsp_host_model.sv
// Purpose: host side serial master model that drives command frames
// Assumes: mode 0, bit time 160 ns, one command per select-low frame
// Notes:   data line flips when idle so stale bits never look valid
`timescale 1ns/1ps
module rsp_host_model (
    // serial pins
    output logic      sck_pin,
    output logic      mosi_pin,
    output logic      select_low,
    input  wire logic miso
);
    logic [7:0] txb [0:39];
    logic [7:0] rxb [0:39];

    // idle levels: clock low, not selected
    initial
    begin
        sck_pin = 1'b0;
        mosi_pin = 1'b0;
        select_low = 1'b1;
    end

    // one frame; sampling is late because the port answers via a synchroniser
    task automatic frame(input int n);
        #3 select_low = 1'b0;
        #160;
        for (int b = 0; b < n; b++)
        begin
            for (int i = 7; i >= 0; i--)
            begin
                mosi_pin = txb[b][i];
                #80 sck_pin = 1'b1;
                #76 rxb[b][i] = miso;
                #4 sck_pin = 1'b0;
            end
        end
        #80 select_low = 1'b1;
        mosi_pin = ~mosi_pin;
        #240;
    endtask
endmodule // rsp_host_model

//--- tb/tb_top.sv
// Purpose: self-checking bench for the radio/converter command port
// Assumes: host model makes frames; flags and payload port driven here
// Notes:   expected bytes come from shadow copies kept in this bench
`timescale 1ns/1ps
module tb_top;
    import rsp_pkg::*;
    logic        mclk, srst, ce, standby, miso, miso_oe, conv_start;
    logic        sck_pin, mosi_pin, select_low, rx_wr_en;
    logic [3:0]  flags, adc_input_select;
    logic [4:0]  rx_wr_idx, tx_rd_idx;
    logic [7:0]  rx_wr_data, tx_rd_data;
    logic [15:0] adc_result, adc_setup_reg;
    logic [31:0] tx_address_reg;
    logic [79:0] rf_setup_reg;
    logic [7:0]  rf_exp [0:9];
    logic [7:0]  ta_exp [0:3];
    logic [7:0]  ac_exp [0:1];
    logic [7:0]  tp_exp [0:31];
    logic [7:0]  rp_exp [0:31];
    logic [7:0]  ops [0:9] = '{8'h00, 8'h10, OP_WTP, OP_RTP, OP_WTA,
                               OP_RTA, OP_RRP, OP_WAC, OP_RAC, 8'hc0};
    int          num_errors = 0;
    int          tests_run = 0;
    int          conv_cnt = 0;

    rsp_host_model rsp_host_model_inst (.sck_pin(sck_pin),
        .mosi_pin(mosi_pin), .select_low(select_low),
        .miso(miso_oe ? miso : ~miso)); // released line reads inverted
    rsp_cmd_port #(.RF_BYTES(RF_NBYTES)) rsp_cmd_port_inst (.mclk(mclk),
        .srst(srst), .ce(ce), .sck_pin(sck_pin), .mosi_pin(mosi_pin),
        .select_low(select_low), .miso(miso), .miso_oe(miso_oe),
        .standby(standby), .data_ready_flag(flags[0]),
        .address_match_flag(flags[1]), .conversion_done_flag(flags[2]),
        .adc_range_flag(flags[3]), .adc_result(adc_result),
        .rx_wr_en(rx_wr_en), .rx_wr_idx(rx_wr_idx), .rx_wr_data(rx_wr_data),
        .tx_rd_idx(tx_rd_idx), .tx_rd_data(tx_rd_data),
        .rf_setup_reg(rf_setup_reg), .tx_address_reg(tx_address_reg),
        .adc_setup_reg(adc_setup_reg), .conv_start(conv_start),
        .adc_input_select(adc_input_select));

    // 50 MHz system clock
    initial
    begin
        mclk = 1'b0;
    end
    always #10 mclk = ~mclk;

    // count conversion start pulses
    always @(posedge mclk)
    begin
        if (conv_start === 1'b1)
            conv_cnt <= conv_cnt + 1;
    end

    task automatic chk_val(input string name, input logic [31:0] exp,
                           input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    // byte a read command should return at position i
    function automatic logic [7:0] rd_exp(input logic [7:0] op, input int i);
        int j;
        j = i + int'(op[3:0]);
        // frames outside standby answer status and then zeros only
        if (standby !== 1'b1)
            return 8'h00;
        case (op)
            OP_RTP: return (i < 32) ? tp_exp[i] : 8'h00;
            OP_RTA: return (i < 4) ? ta_exp[i] : 8'h00;
            OP_RRP: return (i < 32) ? rp_exp[i] : 8'h00;
            OP_RAC: return (i < 2) ? ac_exp[i] : 8'h00;
            {OP_RAD_HI, 1'b0}, {OP_RAD_HI, 1'b1}:
                return (j < 2) ? adc_result[8*j +: 8] : 8'h00;
            default: return (op[7:4] == OP_READ_RADIO_SETUP && j < 10)
                            ? rf_exp[j] : 8'h00;
        endcase
    endfunction

    // shadow update for one written byte; excess bytes fall away
    task automatic upd(input logic [7:0] op, input int i, input logic [7:0] d);
        int j;
        j = i + int'(op[3:0]);
        if (op[7:4] == OP_WRITE_RADIO_SETUP && j < 10)
            rf_exp[j] = d;
        if (op == OP_WTP && i < 32)
            tp_exp[i] = d;
        if (op == OP_WTA && i < 4)
            ta_exp[i] = d;
        if (op == OP_WAC && i < 2)
            ac_exp[i] = d;
        if (op[7:4] == OP_CC_HI && i == 0)
        begin
            rf_exp[0] = d;
            rf_exp[1][3:0] = op[3:0];
        end
    endtask

    task automatic chk_ports();
        for (int k = 0; k < 10; k++)
            chk_val("rf_setup", rf_exp[k], rf_setup_reg[8*k +: 8]);
        for (int k = 0; k < 4; k++)
            chk_val("tx_addr", ta_exp[k], tx_address_reg[8*k +: 8]);
        for (int k = 0; k < 2; k++)
            chk_val("adc_setup", ac_exp[k], adc_setup_reg[8*k +: 8]);
    endtask

    // one framed command with n random data bytes after the opcode
    task automatic cmd(input logic [7:0] op, input int n);
        @(posedge mclk);
        flags <= 4'($urandom);
        @(posedge mclk);
        rsp_host_model_inst.txb[0] = op;
        for (int k = 1; k <= n; k++)
            rsp_host_model_inst.txb[k] = 8'($urandom);
        rsp_host_model_inst.frame(n + 1);
        chk_val("status", {28'h0, flags},
                rsp_host_model_inst.rxb[0]);
        chk_val("oe_idle", 32'h0, miso_oe);
        for (int i = 0; i < n; i++)
            chk_val("read", rd_exp(op, i),
                    rsp_host_model_inst.rxb[i + 1]);
        for (int i = 0; i < n; i++)
            if (standby === 1'b1)
                upd(op, i, rsp_host_model_inst.txb[i + 1]);
        chk_ports();
    endtask

    task automatic give_verdict();
        $display("checks run %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // whole sequence needs about 0.4 ms; 1 ms leaves ample margin
    initial
    begin
        #1_000_000;
        num_errors++;
        give_verdict();
    end

    // main sequence
    initial
    begin
        int c0;
        logic [7:0] op;
        void'($urandom(32'h2e0e7755));
        {srst, ce, standby} = 3'b111;
        {flags, adc_result, rx_wr_en, rx_wr_idx, rx_wr_data, tx_rd_idx} = '0;
        rf_exp = '{default: 8'h00};
        ta_exp = '{default: 8'h00};
        ac_exp = '{default: 8'h00};
        rf_exp[0] = RF_B0_RST;
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        repeat (4) @(posedge mclk);
        chk_ports();
        // packet engine fills the incoming payload
        for (int k = 0; k < 32; k++)
        begin
            rp_exp[k] = 8'($urandom);
            rx_wr_en <= 1'b1;
            rx_wr_idx <= 5'(k);
            rx_wr_data <= rp_exp[k];
            @(posedge mclk);
        end
        rx_wr_en <= 1'b0;
        adc_result <= 16'($urandom);
        cmd(OP_WTA, 5);
        cmd(OP_RTA, 5);
        cmd(OP_WTP, 32);
        cmd(OP_RTP, 33);
        cmd(OP_RRP, 32);
        cmd(8'h03, 9);
        cmd(8'h10, 10);
        cmd(8'h17, 4);
        cmd(OP_WAC, 3);
        cmd(OP_RAC, 3);
        cmd({OP_RAD_HI, 1'b0}, 3);
        cmd({OP_RAD_HI, 1'b1}, 2);
        cmd(8'h25, 4);
        // a short read leaves context that a refused frame must not show
        cmd(OP_RTP, 1);
        @(posedge mclk);
        standby <= 1'b0;
        cmd(OP_WTA, 4);
        cmd(OP_RTP, 4);
        @(posedge mclk);
        standby <= 1'b1;
        // every power/band/channel code and every converter input
        for (int s = 0; s < 16; s++)
        begin
            cmd({OP_CC_HI, 4'(s)}, 1);
            c0 = conv_cnt;
            cmd({OP_SAC_HI, 4'(s)}, 0);
            chk_val("conv_sel", s, adc_input_select);
            chk_val("conv_pulses", c0 + 1, conv_cnt);
        end
        // packet engine read side of the outgoing payload
        for (int k = 0; k < 32; k += 7)
        begin
            @(posedge mclk);
            tx_rd_idx <= 5'(k);
            repeat (2) @(posedge mclk);
            #1 chk_val("tx_rd", tp_exp[k], tx_rd_data);
        end
        // random legal commands
        repeat (12)
        begin
            op = ops[$urandom % 10];
            if (op[7:4] == OP_WRITE_RADIO_SETUP
                || op[7:4] == OP_READ_RADIO_SETUP)
                op[3:0] = 4'($urandom % 10);
            cmd(op, 1 + $urandom % 8);
        end
        give_verdict();
    end
endmodule // tb_top
